/* File: shared/cpb_pkg.sv */
// Purpose: constants and carrier types for the programmable buffers
// Assumes: 8-bit registers on a 32-bit Avalon-MM word bus
// Notes: one word per register; buffer n occupies a 32-byte window
package cpb_pkg;
  // ****************************************
  // sizes
  // ****************************************
  localparam int CPB_NUM_BUF = 6;
  localparam int CPB_IDX_W = 3;
  // ****************************************
  // register map (byte addresses)
  // ****************************************
  localparam logic [7:0] CPB_ADDR_BUF_STRIDE = 8'h20;
  localparam logic [4:0] CPB_OFS_CON = 5'h00;
  localparam logic [4:0] CPB_OFS_SIDH = 5'h04;
  localparam logic [4:0] CPB_OFS_SIDL = 5'h08;
  localparam logic [4:0] CPB_OFS_EIDH = 5'h0C;
  localparam logic [4:0] CPB_OFS_EIDL = 5'h10;
  localparam logic [7:0] CPB_ADDR_BSEL = 8'hC0;
  localparam logic [7:0] CPB_ADDR_MODE = 8'hC4;
  localparam logic [7:0] CPB_ADDR_STAT = 8'hC8;
  // ****************************************
  // field positions
  // ****************************************
  localparam int CPB_BIT_FULL = 7;
  localparam int CPB_BIT_ACCALL = 6;
  localparam int CPB_BIT_RRTR = 5;
  localparam int CPB_BIT_DONE = 7;
  localparam int CPB_BIT_ABT = 6;
  localparam int CPB_BIT_LARB = 5;
  localparam int CPB_BIT_ERR = 4;
  localparam int CPB_BIT_REQ = 3;
  localparam int CPB_BIT_ARR = 2;
  localparam int CPB_BIT_EXT = 3;
  localparam int CPB_BIT_SRR = 4;
  localparam int CPB_BSEL_LSB = 2;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [7:0] CPB_RST_CON = 8'h00;
  localparam logic [7:0] CPB_RST_BSEL = 8'h00;
  localparam logic [1:0] CPB_RST_MODE = 2'h0;
  localparam logic [7:0] CPB_RST_ID = 8'h00;
  localparam logic [4:0] CPB_RST_HIT = 5'h00;
  // ****************************************
  // carrier types
  // ****************************************
  // message arriving from the protocol engine
  typedef struct packed {
    logic valid;
    logic good;
    logic remote;
    logic ext;
    logic substitute_remote_bit;
    logic [28:0] id;
    logic [4:0] hit;
    logic [5:0] match;
  } cpb_rx_msg_t;
  // outcome reported by the protocol engine for the active buffer
  typedef struct packed {
    logic done;
    logic aborted;
    logic arb_lost;
    logic bus_err;
  } cpb_tx_evt_t;
  // selected message offered to the engine
  typedef struct packed {
    logic valid;
    logic [CPB_IDX_W-1:0] idx;
    logic ext;
    logic [28:0] id;
  } cpb_tx_offer_t;
endpackage

/* File: rtl/cpb_prio_pick.sv */
// Purpose: choose the pending transmit buffer of highest priority
// Assumes: ties go to the higher buffer number
// Notes: purely combinational
`timescale 1ns/1ps
module cpb_prio_pick
  import cpb_pkg::*;
(
  // pending requests and their priorities
  input wire logic [CPB_NUM_BUF-1:0] pend_in,
  input wire logic [2*CPB_NUM_BUF-1:0] prio_in,
  // winner
  output logic any_out,
  output logic [CPB_IDX_W-1:0] idx_out
);
  // ****************************************
  // scan
  // ****************************************
  // later index wins ties through >=
  always_comb
  begin
    logic [1:0] best;
    best = 2'h0;
    any_out = 1'b0;
    idx_out = '0;
    for (int i = 0; i < CPB_NUM_BUF; i++)
    begin
      if (pend_in[i] && (!any_out || prio_in[2*i +: 2] >= best))
      begin
        any_out = 1'b1;
        best = prio_in[2*i +: 2];
        idx_out = CPB_IDX_W'(i);
      end
    end
  end
endmodule

/* File: rtl/cpb_buffer.sv */
// Purpose: one programmable transmit/receive message buffer
// Assumes: write strobes already decoded and gated by the top
// Notes: field storage, flags and the auto remote reply
`timescale 1ns/1ps
module cpb_buffer
  import cpb_pkg::*;
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // configuration
  input wire logic is_tx_in,
  input wire logic active_in,
  // software writes
  input wire logic [4:0] wr_sel_in,
  input wire logic [7:0] wr_data_in,
  // protocol engine side
  input wire cpb_rx_msg_t rx_in,
  input wire logic tx_sel_in,
  input wire cpb_tx_evt_t evt_in,
  // register images
  output logic [7:0] con_out,
  output logic [7:0] sidh_out,
  output logic [7:0] sidl_out,
  output logic [7:0] eidh_out,
  output logic [7:0] eidl_out,
  output logic busy_out
);
  logic [7:0] con;
  logic [28:0] id;
  logic ext;
  logic substitute_remote_bit;
  logic take;
  logic req_set;
  logic sw_con;

  assign sw_con = wr_sel_in[0];
  // buffer locked while request pending or sending
  assign busy_out = is_tx_in && con[CPB_BIT_REQ];
  // receive: free, accepted by filter or accept-all
  assign take = active_in && rx_in.valid && !is_tx_in
    && !con[CPB_BIT_FULL]
    && (con[CPB_BIT_ACCALL] || (rx_in.good && rx_in.match[0]));
  // transmit: software set or auto reply to a remote frame
  assign req_set = (sw_con && wr_data_in[CPB_BIT_REQ]
    && !con[CPB_BIT_REQ]) || (active_in && is_tx_in && rx_in.valid
    && rx_in.good && rx_in.remote && rx_in.match[0]
    && con[CPB_BIT_ARR]);

  // ****************************************
  // control register
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
      con <= CPB_RST_CON;
    else if (!is_tx_in)
    begin
      if (take)
      begin
        con[CPB_BIT_FULL] <= 1'b1; // set wins over clear
        con[CPB_BIT_RRTR] <= rx_in.remote;
        con[4:0] <= rx_in.hit;
      end
      else if (sw_con)
        con[CPB_BIT_FULL] <= wr_data_in[CPB_BIT_FULL];
      if (sw_con)
        con[CPB_BIT_ACCALL] <= wr_data_in[CPB_BIT_ACCALL];
    end
    else
    begin
      if (req_set)
      begin
        con[7:4] <= 4'h0;
        con[CPB_BIT_REQ] <= 1'b1;
      end
      else if (tx_sel_in && evt_in.done)
      begin
        con[CPB_BIT_DONE] <= 1'b1;
        con[CPB_BIT_REQ] <= 1'b0;
      end
      else if (sw_con && con[CPB_BIT_REQ]
        && !wr_data_in[CPB_BIT_REQ])
      begin
        con[CPB_BIT_ABT] <= 1'b1; // abort on clear
        con[CPB_BIT_REQ] <= 1'b0;
      end
      else if (tx_sel_in && evt_in.aborted)
      begin
        con[CPB_BIT_ABT] <= 1'b1;
        con[CPB_BIT_REQ] <= 1'b0;
      end
      if (!req_set && tx_sel_in && evt_in.arb_lost)
        con[CPB_BIT_LARB] <= 1'b1;
      if (!req_set && tx_sel_in && evt_in.bus_err)
        con[CPB_BIT_ERR] <= 1'b1;
      if (sw_con && !busy_out)
        con[2:0] <= wr_data_in[2:0];
    end
  end

  // ****************************************
  // identifier storage
  // ****************************************
  always_ff @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      id <= '0;
      ext <= 1'b0;
      substitute_remote_bit <= 1'b0;
    end
    else if (take)
    begin
      id <= rx_in.id;
      ext <= rx_in.ext;
      substitute_remote_bit <= rx_in.ext && rx_in.substitute_remote_bit;
    end
    else if (is_tx_in && !busy_out)
    begin
      // software writes only when idle
      if (wr_sel_in[1])
        id[28:21] <= wr_data_in;
      if (wr_sel_in[2])
      begin
        id[20:18] <= wr_data_in[7:5];
        ext <= wr_data_in[CPB_BIT_EXT];
        id[17:16] <= wr_data_in[1:0];
      end
      if (wr_sel_in[3])
        id[15:8] <= wr_data_in;
      if (wr_sel_in[4])
        id[7:0] <= wr_data_in;
    end
  end

  // ****************************************
  // register images
  // ****************************************
  assign con_out = con;
  assign sidh_out = id[28:21];
  assign sidl_out = {id[20:18], is_tx_in ? 1'b0 : substitute_remote_bit, ext, 1'b0,
    id[17:16]};
  assign eidh_out = id[15:8];
  assign eidl_out = id[7:0];

  // ****************************************
  // checks
  // ****************************************
  property p_full_blocks;
    @(posedge clk_in) disable iff (!rst_n_in)
    (!is_tx_in && con[CPB_BIT_FULL] && !sw_con) ##1 !is_tx_in
      |-> $stable(id);
  endproperty
  a_full_blocks: assert property (p_full_blocks)
    else $error("full receive buffer was overwritten");

  property p_req_clears;
    @(posedge clk_in) disable iff (!rst_n_in)
    is_tx_in && req_set ##1 is_tx_in |-> con[7:4] == 4'h0;
  endproperty
  a_req_clears: assert property (p_req_clears)
    else $error("status flags not cleared by request");

  property p_done_drops_req;
    @(posedge clk_in) disable iff (!rst_n_in)
    is_tx_in && tx_sel_in && evt_in.done && !req_set ##1 is_tx_in
      |-> con[CPB_BIT_DONE] && !con[CPB_BIT_REQ];
  endproperty
  a_done_drops_req: assert property (p_done_drops_req)
    else $error("done did not end the request");

  property p_lock;
    @(posedge clk_in) disable iff (!rst_n_in)
    busy_out && !take |=> $stable(id);
  endproperty
  a_lock: assert property (p_lock)
    else $error("identifier changed while locked");

  property p_rtr_flag;
    @(posedge clk_in) disable iff (!rst_n_in)
    take ##1 !is_tx_in |-> con[CPB_BIT_RRTR] == $past(rx_in.remote)
      && con[4:0] == $past(rx_in.hit) && ext == $past(rx_in.ext);
  endproperty
  a_rtr_flag: assert property (p_rtr_flag)
    else $error("receive status not captured");
endmodule

/* File: rtl/cpb_top.sv */
// Purpose: six programmable message buffers with register access
// Assumes: Avalon-MM slave, protocol engine on the far side
// Notes: one buffer is offered to the engine at a time
//
// Decided for this implementation: the Avalon-MM slave port and the register offsets.
`timescale 1ns/1ps
// Overview of operation
// - six buffers, each transmit or receive, each able to auto-answer remotes
// - buffers inactive in mode 0, usable in modes 1 to 3
// - select register bits 7..2 pick direction of buffers 5..0, 1 is transmit
// - full flag set on store; no new store until software clears it
// - accept-all bit takes every message ignoring filters, else filtered only
// - remote-request flag shows whether stored message was a remote frame
// - filter-hit field records admitting filter, 0 to 31
// - done flag set after successful transmission
// - aborted, arbitration-lost and bus-error flags set on their events
// - setting transmit request clears the four status flags
// - transmit request clears itself after successful sending
// - software clearing a set request asks for an abort
// - buffer registers read-only while request pending or sending
// - auto-reply bit sets the request when a remote frame arrives
// - pending buffers sent by 2-bit priority, identifier untouched
// - identifier high and low byte layout for standard and extended
// - receive extended flag marks extended identifier frames
// - substitute remote bit reported for extended frames only
module cpb_top
  import cpb_pkg::*;
(
  // clock and reset
  input wire logic sys_clk_in,
  input wire logic nrst_in,
  // avalon-mm slave
  input wire logic [7:0] avs_address_in,
  input wire logic avs_read_in,
  input wire logic avs_write_in,
  input wire logic [31:0] avs_writedata_in,
  input wire logic [3:0] avs_byteenable_in,
  output logic [31:0] avs_readdata_out,
  output logic avs_waitrequest_out,
  // protocol engine
  input wire cpb_rx_msg_t rx_msg_in,
  input wire cpb_tx_evt_t tx_evt_in,
  input wire logic tx_start_in,
  output cpb_tx_offer_t tx_offer_out,
  output logic tx_active_out
);
  // ****************************************
  // reset synchroniser
  // ****************************************
  logic rst_meta;
  logic rst_n;
  // two-stage release of the asynchronous reset
  always_ff @(posedge sys_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      rst_meta <= 1'b0;
      rst_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_n <= rst_meta;
    end
  end

  // ****************************************
  // global registers
  // ****************************************
  logic [7:0] buffer_select_register;
  logic [1:0] op_mode;
  logic active;
  logic [CPB_NUM_BUF-1:0] buffer_direction_select;
  logic ack;
  logic wr_go;
  logic [2:0] bufn;
  logic [4:0] ofs;
  logic in_buf;

  assign active = op_mode != 2'h0;
  assign buffer_direction_select =
    buffer_select_register[7:CPB_BSEL_LSB];
  assign bufn = avs_address_in[7:5];
  assign ofs = avs_address_in[4:0];
  assign in_buf = avs_address_in < CPB_ADDR_BSEL;
  assign wr_go = avs_write_in && ack && avs_byteenable_in[0];

  // one wait state: answer on the second cycle of a request
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      ack <= 1'b0;
    else
      ack <= (avs_read_in || avs_write_in) && !ack;
  end
  assign avs_waitrequest_out = (avs_read_in || avs_write_in) && !ack;

  // select register and mode register
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      buffer_select_register <= CPB_RST_BSEL;
      op_mode <= CPB_RST_MODE;
    end
    else if (wr_go)
    begin
      if (avs_address_in == CPB_ADDR_BSEL)
        buffer_select_register <= {avs_writedata_in[7:2], 2'h0};
      if (avs_address_in == CPB_ADDR_MODE)
        op_mode <= avs_writedata_in[1:0];
    end
  end

  // ****************************************
  // transmit scheduling
  // ****************************************
  logic [CPB_NUM_BUF-1:0] pend;
  logic [2*CPB_NUM_BUF-1:0] prio;
  logic pick_any;
  logic [CPB_IDX_W-1:0] pick_idx;
  logic [CPB_IDX_W-1:0] cur_idx;
  logic [7:0] con_img [CPB_NUM_BUF];
  logic [7:0] sidh_img [CPB_NUM_BUF];
  logic [7:0] sidl_img [CPB_NUM_BUF];
  logic [7:0] eidh_img [CPB_NUM_BUF];
  logic [7:0] eidl_img [CPB_NUM_BUF];
  logic [CPB_NUM_BUF-1:0] busy;

  typedef enum logic [1:0] {CPB_IDLE, CPB_OFFER, CPB_SEND} cpb_tx_state_t;
  cpb_tx_state_t tx_state;
  cpb_tx_state_t next_tx_state;

  cpb_prio_pick u_pick (
    .pend_in(pend),
    .prio_in(prio),
    .any_out(pick_any),
    .idx_out(pick_idx)
  );

  // next state of the offer sequence
  always_comb
  begin
    next_tx_state = tx_state;
    case (tx_state)
      CPB_IDLE:
        if (pick_any)
          next_tx_state = CPB_OFFER;
      CPB_OFFER:
        if (!pend[cur_idx])
          next_tx_state = CPB_IDLE;
        else if (tx_start_in)
          next_tx_state = CPB_SEND;
        else if (pick_idx != cur_idx)
          next_tx_state = CPB_IDLE; // better buffer came up, re-pick
      CPB_SEND:
        if (tx_evt_in.done || tx_evt_in.aborted || !pend[cur_idx])
          next_tx_state = CPB_IDLE;
      default:
        next_tx_state = CPB_IDLE;
    endcase
  end

  // state and chosen buffer
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      tx_state <= CPB_IDLE;
      cur_idx <= '0;
    end
    else
    begin
      tx_state <= next_tx_state;
      if (tx_state == CPB_IDLE && pick_any)
        cur_idx <= pick_idx; // highest priority first
    end
  end

  // offer register drives the engine from flip-flops
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      tx_offer_out <= '0;
    else
    begin
      tx_offer_out.valid <= next_tx_state == CPB_OFFER;
      tx_offer_out.idx <= (tx_state == CPB_IDLE) ? pick_idx : cur_idx;
      // identifier passes unchanged, priority is not part of it
      if (tx_state == CPB_IDLE)
      begin
        tx_offer_out.ext <= sidl_img[pick_idx][CPB_BIT_EXT];
        tx_offer_out.id <= {sidh_img[pick_idx],
          sidl_img[pick_idx][7:5], sidl_img[pick_idx][1:0],
          eidh_img[pick_idx], eidl_img[pick_idx]};
      end
    end
  end
  assign tx_active_out = tx_state == CPB_SEND;

  // ****************************************
  // buffers
  // ****************************************
  generate
    for (genvar g = 0; g < CPB_NUM_BUF; g++)
    begin : g_buf
      logic [4:0] wsel;
      logic hit_me;
      cpb_rx_msg_t rx_one;
      assign hit_me = wr_go && in_buf && bufn == 3'(g) && active;
      assign wsel = {hit_me && ofs == CPB_OFS_EIDL,
        hit_me && ofs == CPB_OFS_EIDH, hit_me && ofs == CPB_OFS_SIDL,
        hit_me && ofs == CPB_OFS_SIDH, hit_me && ofs == CPB_OFS_CON};
      // per-buffer filter match moved to bit 0
      always_comb
      begin
        rx_one = rx_msg_in;
        rx_one.match = {5'h00, rx_msg_in.match[g]};
      end
      assign pend[g] = active && buffer_direction_select[g]
        && con_img[g][CPB_BIT_REQ];
      assign prio[2*g +: 2] = con_img[g][1:0];
      cpb_buffer u_buf (
        .clk_in(sys_clk_in),
        .rst_n_in(rst_n),
        .is_tx_in(buffer_direction_select[g]),
        .active_in(active),
        .wr_sel_in(wsel),
        .wr_data_in(avs_writedata_in[7:0]),
        .rx_in(rx_one),
        .tx_sel_in(tx_state == CPB_SEND && cur_idx == 3'(g)),
        .evt_in(tx_evt_in),
        .con_out(con_img[g]),
        .sidh_out(sidh_img[g]),
        .sidl_out(sidl_img[g]),
        .eidh_out(eidh_img[g]),
        .eidl_out(eidl_img[g]),
        .busy_out(busy[g])
      );
    end
  endgenerate

  // ****************************************
  // read data
  // ****************************************
  always_ff @(posedge sys_clk_in or negedge rst_n)
  begin
    if (!rst_n)
      avs_readdata_out <= 32'h0000_0000;
    else if (avs_read_in && !ack)
    begin
      avs_readdata_out <= 32'h0000_0000;
      if (in_buf && bufn < 3'(CPB_NUM_BUF) && active)
        case (ofs)
          CPB_OFS_CON: avs_readdata_out[7:0] <= con_img[bufn];
          CPB_OFS_SIDH: avs_readdata_out[7:0] <= sidh_img[bufn];
          CPB_OFS_SIDL: avs_readdata_out[7:0] <= sidl_img[bufn];
          CPB_OFS_EIDH: avs_readdata_out[7:0] <= eidh_img[bufn];
          CPB_OFS_EIDL: avs_readdata_out[7:0] <= eidl_img[bufn];
          default: avs_readdata_out <= 32'h0000_0000;
        endcase
      else if (avs_address_in == CPB_ADDR_BSEL)
        avs_readdata_out[7:0] <= buffer_select_register;
      else if (avs_address_in == CPB_ADDR_MODE)
        avs_readdata_out[1:0] <= op_mode;
      else if (avs_address_in == CPB_ADDR_STAT)
        avs_readdata_out[7:0] <= {1'b0, tx_state == CPB_SEND, busy};
    end
  end

  // ****************************************
  // checks
  // ****************************************
  property p_mode0_idle;
    @(posedge sys_clk_in) disable iff (!rst_n)
    !active ##1 !active |-> !tx_offer_out.valid && !tx_active_out;
  endproperty
  a_mode0_idle: assert property (p_mode0_idle)
    else $error("buffers active in mode 0");

  sequence s_offer;
    tx_state == CPB_IDLE && pick_any;
  endsequence
  property p_prio_order;
    @(posedge sys_clk_in) disable iff (!rst_n)
    s_offer |=> prio[2*cur_idx +: 2] >= $past(prio[2*pick_idx +: 2])
      || !pend[cur_idx];
  endproperty
  a_prio_order: assert property (p_prio_order)
    else $error("lower priority buffer offered first");

  property p_wait_one;
    @(posedge sys_clk_in) disable iff (!rst_n)
    $rose(avs_read_in) |-> avs_waitrequest_out ##1 !avs_waitrequest_out;
  endproperty
  a_wait_one: assert property (p_wait_one)
    else $error("bus answer not after one wait state");
endmodule

/* File: testbench/cpb_engine_model.sv */
// Purpose: protocol engine stand-in facing the buffer block
// Assumes: one send at a time, outcome picked by the bench
// Notes: receive fields carry inverted junk between messages
`timescale 1ns/1ps
module cpb_engine_model
  import cpb_pkg::*;
#(
  parameter int LAT = 6
)
(
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_n_in,
  // bench control
  input wire logic go_in,
  input wire cpb_tx_evt_t outcome_in,
  // buffer block side
  input wire cpb_tx_offer_t offer_in,
  input wire logic active_in,
  output cpb_rx_msg_t rx_out,
  output cpb_tx_evt_t evt_out,
  output logic start_out
);
  // **********
  // sending
  // **********
  cpb_tx_offer_t log_q[$];
  int cnt;
  initial rx_out = '0;
  // take the offered buffer, report outcome after LAT, then rest
  always @(posedge clk_in or negedge rst_n_in)
  begin
    if (!rst_n_in)
    begin
      cnt <= 0;
      start_out <= 1'b0;
      evt_out <= '0;
    end
    else
    begin
      start_out <= 1'b0;
      evt_out <= '0;
      if (cnt > 0)
        cnt <= cnt - 1;
      if (cnt == LAT)
        evt_out <= outcome_in;
      if (cnt == 0 && go_in && offer_in.valid && !active_in)
      begin
        start_out <= 1'b1;
        log_q.push_back(offer_in);
        cnt <= 2 * LAT;
      end
    end
  end
  // one-cycle message, then junk with valid low
  task automatic send(input cpb_rx_msg_t m);
    @(posedge clk_in);
    rx_out <= m;
    @(posedge clk_in);
    m = ~m;
    m.valid = 1'b0;
    rx_out <= m;
  endtask
endmodule

/* File: testbench/cpb_top_tb.sv */
// Purpose: self-checking bench for the programmable buffers
// Assumes: one wait state per bus access, engine model on far side
// Notes: expected values come from the field layout alone
`timescale 1ns/1ps
module cpb_top_tb;
  import cpb_pkg::*;
  // **********
  // stimulus and wiring
  // **********
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic [7:0] addr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [31:0] wdata = '0;
  logic [31:0] rdata;
  logic wreq;
  logic go = 1'b0;
  cpb_tx_evt_t outc = '0;
  cpb_rx_msg_t rx;
  cpb_tx_evt_t evt;
  cpb_tx_offer_t offer;
  logic start;
  logic active;
  int fail_count = 0;
  int compares = 0;
  localparam logic [28:0] IDA = 29'h15A5C3E7;
  localparam logic [28:0] IDB = 29'h0C3A5F12;
  localparam logic [28:0] IDS = {11'h5A3, 18'h0};
  always #2 clk = ~clk;
  cpb_top DUT (.sys_clk_in(clk), .nrst_in(nrst), .avs_address_in(addr),
    .avs_read_in(rd), .avs_write_in(wr), .avs_writedata_in(wdata),
    .avs_byteenable_in(4'hF), .avs_readdata_out(rdata),
    .avs_waitrequest_out(wreq), .rx_msg_in(rx), .tx_evt_in(evt),
    .tx_start_in(start), .tx_offer_out(offer), .tx_active_out(active));
  cpb_engine_model eng (.clk_in(clk), .rst_n_in(nrst), .go_in(go),
    .outcome_in(outc), .offer_in(offer), .active_in(active),
    .rx_out(rx), .evt_out(evt), .start_out(start));
  // **********
  // helpers
  // **********
  task automatic test_done();
    $display("compares %0d fail_count %0d", compares, fail_count);
    if (fail_count == 0 && compares > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  task automatic check(input string what, input logic [31:0] seen, exp);
    compares++;
    if (seen !== exp)
    begin
      fail_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask
  // one avalon access, held until waitrequest is seen low
  task automatic bus(input logic w, input logic [7:0] a, d,
                     output logic [31:0] q);
    int n;
    @(posedge clk);
    addr <= a;
    rd <= !w;
    wr <= w;
    wdata <= {24'h0, d};
    n = 0;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (wreq !== 1'b0 && n < 50);
    if (n >= 50)
    begin
      fail_count++;
      test_done();
    end
    q = rdata;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask
  task automatic wt(input logic [7:0] a, d);
    logic [31:0] q;
    bus(1'b1, a, d, q);
  endtask
  task automatic rc(input logic [7:0] a, m, e);
    logic [31:0] q;
    bus(1'b0, a, 8'h00, q);
    check($sformatf("reg %h", a), {24'h0, q[7:0] & m}, {24'h0, e});
  endtask
  function automatic logic [7:0] ra(input int n, input logic [4:0] o);
    return 8'(n) * CPB_ADDR_BUF_STRIDE + {3'h0, o};
  endfunction
  function automatic cpb_rx_msg_t mk(input logic g, r, x, s,
    input logic [28:0] id, input logic [4:0] h, input logic [5:0] m);
    return {1'b1, g, r, x, s, id, h, m};
  endfunction
  function automatic logic [28:0] tid(input int n);
    return 29'h01234567 + 29'(n) * 29'h00111111;
  endfunction
  task automatic chk_id(input int n, input logic [28:0] id,
                        input logic x, s);
    rc(ra(n, CPB_OFS_SIDH), 8'hFF, id[28:21]);
    rc(ra(n, CPB_OFS_SIDL), 8'hFF,
       {id[20:18], s, x, 1'b0, id[17:16]});
    rc(ra(n, CPB_OFS_EIDH), 8'hFF, id[15:8]);
    rc(ra(n, CPB_OFS_EIDL), 8'hFF, id[7:0]);
  endtask
  task automatic wait_log(input int k);
    int n;
    for (n = 0; n < 400 && eng.log_q.size() < k; n++)
      @(posedge clk);
    check("send count", eng.log_q.size(), k);
    repeat (16) @(posedge clk);
  endtask
  // **********
  // scenarios
  // **********
  task automatic t_reset();
    for (int n = 0; n < 6; n++)
      rc(ra(n, CPB_OFS_CON), 8'hFF, CPB_RST_CON);
    rc(CPB_ADDR_BSEL, 8'hFF, CPB_RST_BSEL);
    rc(8'hD0, 8'hFF, 8'h00);
    eng.send(mk(1, 0, 0, 0, IDA, 5'h03, 6'h3F));
    wt(ra(2, CPB_OFS_CON), 8'h40);
    wt(CPB_ADDR_MODE, 8'h01);
    rc(ra(0, CPB_OFS_CON), 8'h80, 8'h00);
    $display("test reset done");
  endtask
  task automatic t_rx();
    eng.send(mk(1, 1, 1, 1, IDA, 5'h0F, 6'h01));
    rc(ra(0, CPB_OFS_CON), 8'hFF, 8'hAF);
    chk_id(0, IDA, 1'b1, 1'b1);
    eng.send(mk(1, 0, 1, 0, IDB, 5'h00, 6'h01));
    chk_id(0, IDA, 1'b1, 1'b1);
    wt(ra(0, CPB_OFS_CON), 8'h00);
    eng.send(mk(1, 0, 0, 1, IDS, 5'h00, 6'h01));
    rc(ra(0, CPB_OFS_CON), 8'hFF, 8'h80);
    rc(ra(0, CPB_OFS_SIDH), 8'hFF, IDS[28:21]);
    rc(ra(0, CPB_OFS_SIDL), 8'hF8, {IDS[20:18], 5'h0});
    $display("test receive done");
  endtask
  task automatic t_acc();
    wt(ra(1, CPB_OFS_CON), 8'h40);
    eng.send(mk(0, 0, 0, 0, IDB, 5'h02, 6'h04));
    rc(ra(1, CPB_OFS_CON), 8'hC0, 8'hC0);
    rc(ra(2, CPB_OFS_CON), 8'h80, 8'h00);
    $display("test accept all done");
  endtask
  task automatic t_tx();
    logic [1:0] pri [6] = '{0, 0, 0, 1, 3, 0};
    logic [28:0] id;
    wt(CPB_ADDR_BSEL, 8'hE0);
    wt(CPB_ADDR_MODE, 8'h02);
    for (int n = 3; n < 6; n++)
    begin
      id = tid(n);
      wt(ra(n, CPB_OFS_SIDH), id[28:21]);
      wt(ra(n, CPB_OFS_SIDL), {id[20:18], 2'b01, 1'b0, id[17:16]});
      wt(ra(n, CPB_OFS_EIDH), id[15:8]);
      wt(ra(n, CPB_OFS_EIDL), id[7:0]);
      chk_id(n, id, 1'b1, 1'b0);
      wt(ra(n, CPB_OFS_CON), {6'h02, pri[n]});
    end
    outc <= '{done: 1'b1, default: 1'b0};
    go <= 1'b1;
    wait_log(3);
    go <= 1'b0;
    foreach (eng.log_q[k])
    begin
      check("order", eng.log_q[k].idx, k == 0 ? 4 : k == 1 ? 3 : 5);
      check("ident", eng.log_q[k].id, tid(eng.log_q[k].idx));
      check("ext", eng.log_q[k].ext, 1);
    end
    for (int n = 3; n < 6; n++)
      rc(ra(n, CPB_OFS_CON), 8'hFF, {6'h20, pri[n]});
    eng.log_q.delete();
    $display("test transmit order done");
  endtask
  task automatic t_flags();
    logic [28:0] id;
    id = tid(3);
    wt(ra(3, CPB_OFS_CON), 8'h09);
    outc <= '{done: 1'b0, default: 1'b1};
    go <= 1'b1;
    repeat (5) @(posedge clk);
    check("sending", active, 1'b1);
    wait_log(1);
    go <= 1'b0;
    rc(ra(3, CPB_OFS_CON), 8'hF0, 8'h70);
    wt(ra(3, CPB_OFS_CON), 8'h09);
    rc(ra(3, CPB_OFS_CON), 8'hFF, 8'h09);
    wt(ra(3, CPB_OFS_SIDH), ~id[28:21]);
    rc(ra(3, CPB_OFS_SIDH), 8'hFF, id[28:21]);
    wt(ra(3, CPB_OFS_CON), 8'h01);
    rc(ra(3, CPB_OFS_CON), 8'h48, 8'h40);
    eng.log_q.delete();
    $display("test flags done");
  endtask
  task automatic t_auto();
    wt(ra(5, CPB_OFS_CON), 8'h04);
    wt(ra(4, CPB_OFS_CON), 8'h03);
    eng.send(mk(1, 1, 0, 0, IDS, 5'h00, 6'h30));
    rc(ra(5, CPB_OFS_CON), 8'h0C, 8'h0C);
    rc(ra(4, CPB_OFS_CON), 8'h08, 8'h00);
    check("offer", {offer.valid, offer.idx}, 4'hD);
    rc(CPB_ADDR_STAT, 8'hFF, 8'h20);
    wt(CPB_ADDR_MODE, 8'h00);
    repeat (2) @(posedge clk);
    check("mode 0", {offer.valid, active}, 2'h0);
    $display("test auto reply done");
  endtask
  // **********
  // main sequence and hang guard
  // **********
  initial
  begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (5) @(posedge clk);
    t_reset();
    t_rx();
    t_acc();
    t_tx();
    t_flags();
    t_auto();
    test_done();
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fail_count++;
    test_done();
  end
endmodule
